// File: verilog/cps_pkg.sv
// package for the charge-pump sequencer and pump clock select block
// assumes a single 125 MHz clock that stands in for the internal oscillator
`default_nettype none
package cps_pkg;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_MHZ = 125;          // sequencing clock rate in MHz
  localparam int START_US = 9400;        // least startup interval at 1 MHz
  localparam int STOP_US = 7500;         // longest stop sequence
  localparam int MASK_US = 18000;        // nominal protection masking time
  localparam int NEG_DELAY_US = 6100;    // delay after positive rail is up
  localparam int START_CYC = START_US * CLK_MHZ;
  localparam int STOP_CYC = STOP_US * CLK_MHZ;
  localparam int MASK_CYC = MASK_US * CLK_MHZ;
  localparam int NEG_DELAY_CYC = NEG_DELAY_US * CLK_MHZ;
  localparam int PUMP_BASE_KHZ = 1000;   // fastest internal pump rate
  localparam int PUMP_BASE_CYC = CLK_MHZ * 1000 / PUMP_BASE_KHZ;
  localparam int TMR_W = 22;
  localparam int DIV_W = 11;

  // ------------------------------------------------------------------
  // register port
  // ------------------------------------------------------------------
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_MASK = 4'h4;
  localparam logic [3:0] ADDR_STATE = 4'h8;
  localparam int EVT_LATCH = 0;
  localparam int EVT_STARTED = 1;
  localparam int EVT_STOPPED = 2;
  localparam logic [2:0] STATUS_RST = 3'h0;
  localparam logic [2:0] MASK_RST = 3'h0;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    CPS_OFF   = 3'b000,
    CPS_START = 3'b001,
    CPS_RUN   = 3'b011,
    CPS_STOP  = 3'b010,
    CPS_LATCH = 3'b110
  } cps_state_e;

  // pump clock selection: source and divider code
  typedef struct packed {
    logic ext;
    logic [1:0] code;
  } cps_sel_s;

endpackage
`default_nettype wire

// File: verilog/cps_top.sv
// charge-pump start/stop sequencer with short-circuit latch-off and pump clock select
// assumes pins arrive asynchronously and i_clk is the free-running oscillator
`timescale 1ns/1ns
`default_nettype none

module cps_top #(
  parameter int START_CYC = cps_pkg::START_CYC,
  parameter int STOP_CYC = cps_pkg::STOP_CYC,
  parameter int MASK_CYC = cps_pkg::MASK_CYC,
  parameter int NEG_DELAY_CYC = cps_pkg::NEG_DELAY_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_en,
  input wire logic i_freq_select_bit0,
  input wire logic i_freq_select_bit1,
  input wire logic i_clk_src_sel,
  input wire logic i_ext_clk,
  input wire logic i_short_positive_rail,
  input wire logic i_short_negative_rail,
  input wire logic i_positive_rail_ok,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_pump_clk,
  output logic o_positive_rail_en,
  output logic o_negative_rail_en,
  output logic o_latched_off,
  output logic o_irq
);

  // refuse interval counts that the timers cannot hold
  if (START_CYC < 1 || STOP_CYC < 1 || MASK_CYC < 1 || NEG_DELAY_CYC < 1 ||
      START_CYC >= (1 << cps_pkg::TMR_W) || MASK_CYC >= (1 << cps_pkg::TMR_W) ||
      STOP_CYC >= (1 << cps_pkg::TMR_W) || NEG_DELAY_CYC >= (1 << cps_pkg::TMR_W)) begin : g_bad_interval
    $error("cps_top: interval counts out of range");
  end

  localparam logic [cps_pkg::TMR_W-1:0] START_LAST = cps_pkg::TMR_W'(START_CYC - 1);
  localparam logic [cps_pkg::TMR_W-1:0] STOP_LAST = cps_pkg::TMR_W'(STOP_CYC - 1);
  localparam logic [cps_pkg::TMR_W-1:0] MASK_LAST = cps_pkg::TMR_W'(MASK_CYC - 1);
  localparam logic [cps_pkg::TMR_W-1:0] NEG_LAST = cps_pkg::TMR_W'(NEG_DELAY_CYC - 1);

  // internal pump period in oscillator cycles for a divider code
  function automatic logic [cps_pkg::DIV_W-1:0] int_period(input logic [1:0] code);
    int_period = cps_pkg::DIV_W'(cps_pkg::PUMP_BASE_CYC) << code;
  endfunction

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  logic [7:0] pin_meta;
  logic [7:0] pin_sync;
  logic ext_clk_q;
  logic en_s;
  logic en_q;
  logic ext_rise;
  logic short_s;
  logic pos_ok_s;
  cps_pkg::cps_sel_s pin_sel;

  // two flops on every pin before use
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
    end else begin
      pin_meta <= {i_positive_rail_ok, i_short_negative_rail, i_short_positive_rail, i_ext_clk,
                   i_clk_src_sel, i_freq_select_bit1, i_freq_select_bit0, i_en};
      pin_sync <= pin_meta;
    end
  end

  // edge history of enable and external clock
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      en_q <= 1'b0;
      ext_clk_q <= 1'b0;
    end else begin
      en_q <= en_s;
      ext_clk_q <= pin_sync[4];
    end
  end

  assign en_s = pin_sync[0];
  assign ext_rise = pin_sync[4] && !ext_clk_q;
  assign short_s = pin_sync[5] || pin_sync[6];
  assign pos_ok_s = pin_sync[7];
  assign pin_sel = '{ext: pin_sync[3], code: pin_sync[2:1]};

  // ------------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------------
  cps_pkg::cps_state_e state;
  cps_pkg::cps_state_e next_state;
  logic [cps_pkg::TMR_W-1:0] seq_tmr;
  logic [cps_pkg::TMR_W-1:0] mask_tmr;
  logic [cps_pkg::TMR_W-1:0] neg_tmr;
  logic armed;
  logic mask_done;
  logic seq_done;
  logic fault;
  cps_pkg::cps_sel_s run_sel;

  assign seq_done = (state == cps_pkg::CPS_START && seq_tmr == START_LAST) ||
                    (state == cps_pkg::CPS_STOP && seq_tmr == STOP_LAST);
  assign fault = short_s && mask_done;

  // next state of the start/stop sequence
  always_comb begin
    next_state = state;
    case (state)
      cps_pkg::CPS_OFF: begin
        if (en_s && !en_q && armed) begin
          next_state = cps_pkg::CPS_START;
        end
      end
      cps_pkg::CPS_START: begin
        if (fault) begin
          next_state = cps_pkg::CPS_LATCH;
        end else if (!en_s) begin
          next_state = cps_pkg::CPS_STOP;
        end else if (seq_done) begin
          next_state = cps_pkg::CPS_RUN;
        end
      end
      cps_pkg::CPS_RUN: begin
        if (fault) begin
          next_state = cps_pkg::CPS_LATCH;
        end else if (!en_s) begin
          next_state = cps_pkg::CPS_STOP;
        end
      end
      cps_pkg::CPS_STOP: begin
        if (seq_done) begin
          next_state = cps_pkg::CPS_OFF;
        end
      end
      cps_pkg::CPS_LATCH: begin
        if (!en_s) begin
          next_state = cps_pkg::CPS_OFF;
        end
      end
      default: next_state = cps_pkg::CPS_OFF;
    endcase
  end

  // state register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= cps_pkg::CPS_OFF;
    end else begin
      state <= next_state;
    end
  end

  // a start is allowed only once enable has been seen low after reset
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      armed <= 1'b0;
    end else if (!en_s) begin
      armed <= 1'b1;
    end
  end

  // startup and stop interval timer on the oscillator clock
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      seq_tmr <= '0;
    end else if (next_state != state) begin
      seq_tmr <= '0;
    end else if (state == cps_pkg::CPS_START || state == cps_pkg::CPS_STOP) begin
      seq_tmr <= seq_tmr + 1'b1;
    end
  end

  // protection masking timer from each start
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mask_tmr <= '0;
      mask_done <= 1'b0;
    end else if (state == cps_pkg::CPS_OFF) begin
      mask_tmr <= '0;
      mask_done <= 1'b0;
    end else if (!mask_done) begin
      mask_tmr <= mask_tmr + 1'b1;
      mask_done <= (mask_tmr == MASK_LAST);
    end
  end

  // selection taken when startup ends, held until stopped
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_sel <= '0;
    end else if (state == cps_pkg::CPS_OFF) begin
      run_sel <= '0; // a stop after an aborted startup stays on 1 MHz
    end else if (state == cps_pkg::CPS_START && next_state == cps_pkg::CPS_RUN) begin
      run_sel <= pin_sel;
    end
  end

  // ------------------------------------------------------------------
  // rail enables
  // ------------------------------------------------------------------
  logic pump_on;
  logic neg_stage;

  assign pump_on = (state == cps_pkg::CPS_START) || (state == cps_pkg::CPS_RUN) ||
                   (state == cps_pkg::CPS_STOP);
  assign neg_stage = (state == cps_pkg::CPS_START) || (state == cps_pkg::CPS_RUN);

  // negative rail waits for the positive monitor plus a delay
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      neg_tmr <= '0;
      o_negative_rail_en <= 1'b0;
    end else if (!neg_stage || !pos_ok_s) begin
      neg_tmr <= '0;
      o_negative_rail_en <= 1'b0;
    end else if (neg_tmr == NEG_LAST) begin
      o_negative_rail_en <= 1'b1;
    end else begin
      neg_tmr <= neg_tmr + 1'b1;
    end
  end

  // positive rail held through the stop sequence, dropped on latch-off
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_positive_rail_en <= 1'b0;
      o_latched_off <= 1'b0;
    end else begin
      o_positive_rail_en <= (next_state == cps_pkg::CPS_START) || (next_state == cps_pkg::CPS_RUN) ||
                            (next_state == cps_pkg::CPS_STOP);
      o_latched_off <= (next_state == cps_pkg::CPS_LATCH);
    end
  end

  // ------------------------------------------------------------------
  // pump clock
  // ------------------------------------------------------------------
  cps_pkg::cps_sel_s pump_sel;
  logic [cps_pkg::DIV_W-1:0] int_cnt;
  logic [cps_pkg::DIV_W-1:0] int_per;
  logic [3:0] ext_cnt;
  logic ext_phase;

  // startup forces internal 1 MHz whatever the pins say
  assign pump_sel = (state == cps_pkg::CPS_START) ? cps_pkg::cps_sel_s'('0) : run_sel;
  assign int_per = int_period(pump_sel.code);

  // internal divider from the oscillator
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      int_cnt <= '0;
    end else if (!pump_on || int_cnt >= int_per - 1'b1) begin
      int_cnt <= '0;
    end else begin
      int_cnt <= int_cnt + 1'b1;
    end
  end

  // external divider: toggle every 2^code rising edges
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ext_cnt <= '0;
      ext_phase <= 1'b0;
    end else if (!pump_on || !pump_sel.ext) begin
      ext_cnt <= '0;
      ext_phase <= 1'b0;
    end else if (ext_rise) begin
      if (ext_cnt == 4'((1 << pump_sel.code) - 1)) begin
        ext_cnt <= '0;
        ext_phase <= !ext_phase;
      end else begin
        ext_cnt <= ext_cnt + 1'b1;
      end
    end
  end

  // pump clock output register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pump_clk <= 1'b0;
    end else if (!pump_on) begin
      o_pump_clk <= 1'b0;
    end else if (pump_sel.ext) begin
      o_pump_clk <= ext_phase;
    end else begin
      o_pump_clk <= (int_cnt < (int_per >> 1));
    end
  end

  // ------------------------------------------------------------------
  // status, mask and read port
  // ------------------------------------------------------------------
  logic [2:0] status;
  logic [2:0] irq_mask;
  logic [2:0] evt;

  assign evt[cps_pkg::EVT_LATCH] = (next_state == cps_pkg::CPS_LATCH) && (state != cps_pkg::CPS_LATCH);
  assign evt[cps_pkg::EVT_STARTED] = (state == cps_pkg::CPS_START) && (next_state == cps_pkg::CPS_RUN);
  assign evt[cps_pkg::EVT_STOPPED] = (state == cps_pkg::CPS_STOP) && (next_state == cps_pkg::CPS_OFF);

  // sticky events, write one to clear, a new event wins
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      status <= cps_pkg::STATUS_RST;
    end else if (i_wr && i_addr == cps_pkg::ADDR_STATUS) begin
      status <= (status & ~i_wdata[2:0]) | evt;
    end else begin
      status <= status | evt;
    end
  end

  // interrupt mask
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_mask <= cps_pkg::MASK_RST;
    end else if (i_wr && i_addr == cps_pkg::ADDR_MASK) begin
      irq_mask <= i_wdata[2:0];
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      case (i_addr)
        cps_pkg::ADDR_STATUS: o_rdata <= {29'h0, status};
        cps_pkg::ADDR_MASK: o_rdata <= {29'h0, irq_mask};
        cps_pkg::ADDR_STATE: o_rdata <= {26'h0, o_negative_rail_en, o_positive_rail_en, mask_done, state};
        default: o_rdata <= '0;
      endcase
    end else begin
      o_rdata <= '0;
    end
  end

  assign o_irq = |(status & irq_mask);

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  sequence s_start_entry;
    state == cps_pkg::CPS_OFF ##1 state == cps_pkg::CPS_START;
  endsequence

  property p_start_internal;
    @(posedge i_clk) disable iff (!i_rst_n)
    state == cps_pkg::CPS_START |-> !pump_sel.ext && pump_sel.code == 2'b00 &&
      int_per == cps_pkg::DIV_W'(cps_pkg::PUMP_BASE_CYC);
  endproperty
  a_start_internal: assert property (p_start_internal) else $error("startup pump not internal 1 MHz");

  property p_start_len;
    @(posedge i_clk) disable iff (!i_rst_n)
    s_start_entry |-> seq_tmr == '0 ##1 (state != cps_pkg::CPS_RUN)[*8];
  endproperty
  a_start_len: assert property (p_start_len) else $error("startup ended too early");

  property p_run_sel;
    @(posedge i_clk) disable iff (!i_rst_n)
    evt[cps_pkg::EVT_STARTED] |=> state == cps_pkg::CPS_RUN && run_sel == $past(pin_sel);
  endproperty
  a_run_sel: assert property (p_run_sel) else $error("selection not taken at end of startup");

  property p_latch;
    @(posedge i_clk) disable iff (!i_rst_n)
    neg_stage && short_s && mask_done |=> state == cps_pkg::CPS_LATCH ##1 !o_positive_rail_en && !o_pump_clk;
  endproperty
  a_latch: assert property (p_latch) else $error("short did not latch the device off");

  property p_latch_hold;
    @(posedge i_clk) disable iff (!i_rst_n)
    state == cps_pkg::CPS_LATCH && en_s |=> state == cps_pkg::CPS_LATCH;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch-off left without enable low");

  property p_mask;
    @(posedge i_clk) disable iff (!i_rst_n)
    !mask_done && state != cps_pkg::CPS_LATCH |=> state != cps_pkg::CPS_LATCH;
  endproperty
  a_mask: assert property (p_mask) else $error("short acted inside masking interval");

  property p_stop;
    @(posedge i_clk) disable iff (!i_rst_n)
    state == cps_pkg::CPS_RUN && !en_s && !fault |=> state == cps_pkg::CPS_STOP ##1 o_positive_rail_en;
  endproperty
  a_stop: assert property (p_stop) else $error("stop sequence not entered");

  property p_off_idle;
    @(posedge i_clk) disable iff (!i_rst_n)
    state == cps_pkg::CPS_OFF && !en_s |=> state == cps_pkg::CPS_OFF ##1 !o_pump_clk;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("started without enable high");

  property p_neg_rail;
    @(posedge i_clk) disable iff (!i_rst_n)
    $rose(o_negative_rail_en) |-> $past(pos_ok_s) && neg_tmr == NEG_LAST;
  endproperty
  a_neg_rail: assert property (p_neg_rail) else $error("negative rail started early");

endmodule // cps_top

`default_nettype wire

// File: tb/cps_host.sv
// host controller model: drives enable, frequency and source selects, external clock
// assumes the bench asks for enable and selection levels in step with i_clk
`timescale 1ns/1ns
`default_nettype none

module cps_host #(
  parameter int START_CYC = 600,
  parameter int EXT_HALF = 4
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_want_en,
  input wire cps_pkg::cps_sel_s i_want_sel,
  output logic o_en,
  output logic o_freq_select_bit0,
  output logic o_freq_select_bit1,
  output logic o_clk_src_sel,
  output logic o_ext_clk
);
  int age;
  int ext_cnt;

  // ------------------------------------------------------------------
  // pin drivers
  // ------------------------------------------------------------------
  // enable stays low through reset, then follows the request
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_en <= 1'b0;
    end else begin
      o_en <= i_want_en;
    end
  end

  // selects move only while disabled or early in startup
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      age <= 0;
      {o_clk_src_sel, o_freq_select_bit1, o_freq_select_bit0} <= 3'h0;
    end else begin
      age <= o_en ? age + 1 : 0;
      if (!o_en || age < START_CYC / 2) begin
        {o_clk_src_sel, o_freq_select_bit1, o_freq_select_bit0} <= i_want_sel;
      end
    end
  end

  // free-running external clock, well below a quarter of i_clk
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ext_cnt <= 0;
      o_ext_clk <= 1'b0;
    end else if (ext_cnt == EXT_HALF - 1) begin
      ext_cnt <= 0;
      o_ext_clk <= !o_ext_clk;
    end else begin
      ext_cnt <= ext_cnt + 1;
    end
  end
endmodule // cps_host
`default_nettype wire

// File: tb/cps_top_bench.sv
// self-checking bench for the charge-pump sequencer with shortened intervals
// assumes cps_pkg, cps_top and cps_host are compiled first
`timescale 1ns/1ns
`default_nettype none

module cps_top_bench;
  localparam int ST = 600;
  localparam int SP = 150;
  localparam int MK = 900;
  localparam int NG = 400;
  localparam int EH = 4;
  logic i_clk, i_rst_n, want_en, i_short_positive_rail, i_short_negative_rail, i_positive_rail_ok;
  logic en, fs0, fs1, src, ext, i_wr, i_rd;
  logic [3:0] i_addr;
  logic [31:0] i_wdata, o_rdata, rv;
  logic o_pump_clk, o_positive_rail_en, o_negative_rail_en, o_latched_off, o_irq;
  cps_pkg::cps_sel_s want_sel;
  int fail_count, comparisons, cyc, t0, p;

  // ------------------------------------------------------------------
  // instances and clock
  // ------------------------------------------------------------------
  cps_host #(.START_CYC(ST), .EXT_HALF(EH)) host (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_want_en(want_en),
    .i_want_sel(want_sel), .o_en(en), .o_freq_select_bit0(fs0), .o_freq_select_bit1(fs1),
    .o_clk_src_sel(src), .o_ext_clk(ext));
  cps_top #(.START_CYC(ST), .STOP_CYC(SP), .MASK_CYC(MK), .NEG_DELAY_CYC(NG)) dut (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_en(en), .i_freq_select_bit0(fs0), .i_freq_select_bit1(fs1), .i_clk_src_sel(src),
    .i_ext_clk(ext), .i_short_positive_rail(i_short_positive_rail), .i_short_negative_rail(i_short_negative_rail),
    .i_positive_rail_ok(i_positive_rail_ok), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_pump_clk(o_pump_clk), .o_positive_rail_en(o_positive_rail_en),
    .o_negative_rail_en(o_negative_rail_en), .o_latched_off(o_latched_off), .o_irq(o_irq));

  // clock of 8 ns period
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = !i_clk;
  end

  // free cycle count for timing checks
  always @(posedge i_clk) cyc <= cyc + 1;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    d = o_rdata;
  endtask

  task automatic till(input int n);
    while (cyc < n) @(negedge i_clk);
  endtask

  // wait for a level on the pump clock, bounded
  task automatic lvl(input logic v);
    int k;
    k = 0;
    while (o_pump_clk !== v && k < 3000) begin
      @(negedge i_clk);
      k++;
    end
  endtask

  // cycles between two rising pump clock edges
  task automatic period(output int n);
    lvl(1'b0);
    lvl(1'b1);
    n = cyc;
    lvl(1'b0);
    lvl(1'b1);
    n = cyc - n;
  endtask

  // enable on, wait for the positive rail
  task automatic start();
    int k;
    k = 0;
    @(posedge i_clk);
    want_en <= 1'b1;
    while (o_positive_rail_en !== 1'b1 && k < 20) begin
      @(negedge i_clk);
      k++;
    end
    t0 = cyc;
  endtask

  function automatic int exp_per(input logic s, input logic [1:0] c);
    return s ? (4 * EH) << c : 125 << c;
  endfunction

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  // start with a random selection, change it inside startup, then stop
  task automatic run_case(input logic s, input logic [1:0] c);
    @(posedge i_clk);
    want_sel <= 3'($urandom);
    till(cyc + 20);
    start();
    chk("pos_en up", 1, o_positive_rail_en);
    @(posedge i_clk);
    i_positive_rail_ok <= 1'b1;
    want_sel <= {s, c};
    period(p);
    chk("start period", 125, p);
    till(t0 + NG - 10);
    chk("neg early", 0, o_negative_rail_en);
    till(t0 + NG + 20);
    chk("neg late", 1, o_negative_rail_en);
    till(t0 + ST - 10);
    rd(4'h8, rv);
    chk("state start", 1, 32'(rv[2:0]));
    till(t0 + ST + 10);
    rd(4'h8, rv);
    chk("state run", 3, 32'(rv[2:0]));
    period(p);
    chk("run period", exp_per(s, c), p);
    chk("irq masked", 0, o_irq);
    @(posedge i_clk);
    want_en <= 1'b0;
    t0 = cyc;
    till(t0 + 10);
    chk("neg stop", 0, o_negative_rail_en);
    chk("pos held", 1, o_positive_rail_en);
    till(t0 + SP - 10);
    chk("pos held late", 1, o_positive_rail_en);
    till(t0 + SP + 10);
    chk("pos off", 0, o_positive_rail_en);
    chk("pump off", 0, o_pump_clk);
    @(posedge i_clk);
    i_positive_rail_ok <= 1'b0;
    rd(4'h0, rv);
    chk("start event", 1, 32'(rv[1]));
    chk("stop event", 1, 32'(rv[2]));
    wr(4'h0, 32'h0000_0007);
    $display("test select %0d%0d done", s, c);
  endtask

  // short inside and after masking, latch-off, irq, enable-toggle recovery
  task automatic fault();
    wr(4'h4, 32'h0000_0001);
    start();
    chk("irq idle", 0, o_irq);
    @(posedge i_clk);
    i_short_positive_rail <= 1'b1;
    i_positive_rail_ok <= 1'b1;
    repeat (5) @(posedge i_clk);
    i_short_positive_rail <= 1'b0;
    till(cyc + 10);
    chk("masked short", 0, o_latched_off);
    till(t0 + MK + 20);
    chk("neg before short", 1, o_negative_rail_en);
    @(posedge i_clk);
    i_short_negative_rail <= 1'b1;
    repeat (10) @(posedge i_clk);
    i_short_negative_rail <= 1'b0;
    till(cyc + 2);
    chk("latched", 1, o_latched_off);
    chk("pos latched", 0, o_positive_rail_en);
    chk("neg latched", 0, o_negative_rail_en);
    chk("pump latched", 0, o_pump_clk);
    chk("irq set", 1, o_irq);
    rd(4'h8, rv);
    chk("state latch", 6, 32'(rv[2:0]));
    wr(4'h0, 32'h0000_0001);
    till(cyc + 3);
    chk("irq clear", 0, o_irq);
    till(cyc + 50);
    chk("latch holds", 1, o_latched_off);
    @(posedge i_clk);
    want_en <= 1'b0;
    till(cyc + 10);
    chk("latch cleared", 0, o_latched_off);
    start();
    chk("restart", 1, o_positive_rail_en);
    @(posedge i_clk);
    want_en <= 1'b0;
    till(cyc + SP + 20);
    chk("restart off", 0, o_positive_rail_en);
    @(posedge i_clk);
    i_positive_rail_ok <= 1'b0;
    $display("test fault done");
  endtask

  task automatic results();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------------
  initial begin
    {i_rst_n, want_en, i_short_positive_rail, i_short_negative_rail, i_positive_rail_ok} = 5'h00;
    {i_wr, i_rd, i_addr, i_wdata} = '0;
    want_sel = 3'h0;
    {fail_count, comparisons, cyc} = '0;
    void'($urandom(32'hbcfa));
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(negedge i_clk);
    chk("reset outputs", 0, {o_pump_clk, o_positive_rail_en, o_negative_rail_en, o_latched_off, o_irq});
    for (int a = 0; a < 16; a += 4) begin
      rd(4'(a), rv);
      chk("reset reg", 0, rv);
    end
    $display("test reset done");
    for (int i = 0; i < 8; i++) run_case(i[2], i[1:0]);
    fault();
    results();
  end

  // cut a hang short
  initial begin
    #(8 * 80000);
    fail_count++;
    results();
  end
endmodule // cps_top_bench
`default_nettype wire
